/* File: rtl/external_interrupt_inputs.sv */
// two external interrupt inputs with pin select, polarity, sense and flags
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_cfg.svh"

// Overview of operation
// - each input has its own polarity bit, active high or low
// - each input has its own bit choosing level or edge detection
// - sense 1 is edge, 0 level; polarity 0 low, 1 high
// - watched pin comes from a config field, independent of pin routing
// - watching a pin only samples it, never disturbs its peripheral
// - first flag at bit 1, second at bit 3 of timer control
// - edge mode flag clears by hardware when the cpu vectors
// - level mode flag reads 1 while input active, else 0
module external_interrupt_inputs #(
  parameter int NUM_PINS = `EXT_IRQ_NUM_PINS
) (
  input  wire logic                          ref_clk_i,
  input  wire logic                          rst_n_i,
  input  wire logic [NUM_PINS-1:0]           port_pins_i,
  input  wire logic [1:0]                    vector_ack_i,
  input  wire logic [`EXT_IRQ_ADDR_W-1:0]    addr_i,
  input  wire logic [`EXT_IRQ_DATA_W-1:0]    wr_data_i,
  input  wire logic                          wr_en_i,
  input  wire logic                          rd_en_i,
  output logic      [`EXT_IRQ_DATA_W-1:0]    rd_data_o,
  output logic                               irq_a_pending_o,
  output logic                               irq_b_pending_o
);

  // ****************************************************************
  // elaboration checks
  // ****************************************************************
  // the select field is three bits wide, so at most eight pins fit
  if (NUM_PINS < 1 || NUM_PINS > (1 << `EXT_IRQ_PIN_SEL_W)) begin : g_bad_pins
    $error("NUM_PINS out of range for the pin select field");
  end

  // the select type and the select field must agree, or pins alias
  if ($bits(ext_irq_pkg::pin_sel_t) != `EXT_IRQ_PIN_SEL_W) begin : g_bad_sel_w
    $error("pin select type and field width differ");
  end

  // two channels and an eight bit register layout are wired in below
  if (`EXT_IRQ_NUM_INPUTS != 2) begin : g_bad_inputs
    $error("exactly two interrupt inputs are supported");
  end

  if (`EXT_IRQ_DATA_W < 8) begin : g_bad_data_w
    $error("register data narrower than its fields");
  end

  // select and polarity fields must not overlap inside the config byte
  if ((`EXT_IRQ_CFG_A_SEL_LSB + `EXT_IRQ_PIN_SEL_W > `EXT_IRQ_CFG_A_POL_BIT) ||
      (`EXT_IRQ_CFG_B_SEL_LSB + `EXT_IRQ_PIN_SEL_W > `EXT_IRQ_CFG_B_POL_BIT)) begin : g_bad_fields
    $error("config fields overlap");
  end

  if (`EXT_IRQ_CONFIG_OFFSET == `EXT_IRQ_TIMER_CTL_OFFSET) begin : g_bad_offsets
    $error("register offsets collide");
  end

  // ****************************************************************
  // pin synchroniser
  // ****************************************************************
  // pins are only sampled here
  logic [NUM_PINS-1:0] pin_meta_r;
  logic [NUM_PINS-1:0] pin_sync_r;

  // two flops before any logic
  // left unreset: they hold real pin levels by release, so no false level flag
  always_ff @(posedge ref_clk_i) begin
    pin_meta_r <= port_pins_i;
    pin_sync_r <= pin_meta_r;
  end

  // ****************************************************************
  // register file
  // ****************************************************************
  ext_irq_pkg::reg_byte_t ext_irq_config_reg_r;
  logic [1:0]             edge_select_r;
  logic                   cfg_wr;
  logic                   tctl_wr;

  assign cfg_wr  = wr_en_i && (addr_i == `EXT_IRQ_CONFIG_OFFSET);
  assign tctl_wr = wr_en_i && (addr_i == `EXT_IRQ_TIMER_CTL_OFFSET);

  // pin select and polarity live here
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      ext_irq_config_reg_r <= `EXT_IRQ_CONFIG_RESET;
    end else if (cfg_wr) begin
      ext_irq_config_reg_r <= wr_data_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      edge_select_r <= 2'b00;
    end else if (tctl_wr) begin
      edge_select_r[0] <= wr_data_i[`EXT_IRQ_TCTL_A_EDGE_BIT];
      edge_select_r[1] <= wr_data_i[`EXT_IRQ_TCTL_B_EDGE_BIT];
    end
  end

  // ****************************************************************
  // per channel detection
  // ****************************************************************
  ext_irq_pkg::irq_vec_t pending;
  ext_irq_pkg::pin_sel_t pin_sel [2];
  logic [1:0]            polarity;
  logic [1:0]            sw_value;

  assign pin_sel[0]  = ext_irq_config_reg_r[`EXT_IRQ_CFG_A_SEL_LSB +: `EXT_IRQ_PIN_SEL_W];
  assign pin_sel[1]  = ext_irq_config_reg_r[`EXT_IRQ_CFG_B_SEL_LSB +: `EXT_IRQ_PIN_SEL_W];
  assign polarity[0] = ext_irq_config_reg_r[`EXT_IRQ_CFG_A_POL_BIT];
  assign polarity[1] = ext_irq_config_reg_r[`EXT_IRQ_CFG_B_POL_BIT];
  assign sw_value[0] = wr_data_i[`EXT_IRQ_TCTL_A_PEND_BIT];
  assign sw_value[1] = wr_data_i[`EXT_IRQ_TCTL_B_PEND_BIT];

  for (genvar ch = 0; ch < `EXT_IRQ_NUM_INPUTS; ch++) begin : g_chan
    logic pin_level;

    // selected pin feeds the channel
    // a select beyond the pin count reads as low rather than wrapping
    assign pin_level = (int'(pin_sel[ch]) < NUM_PINS) ? pin_sync_r[pin_sel[ch]] : 1'b0;

    ext_irq_detect u_detect (
      .ref_clk_i     (ref_clk_i),
      .rst_n_i       (rst_n_i),
      .pin_level_i   (pin_level),
      .polarity_i    (polarity[ch]),
      .edge_select_i (edge_select_r[ch]),
      .vector_ack_i  (vector_ack_i[ch]),
      .sw_write_i    (tctl_wr),
      .sw_value_i    (sw_value[ch]),
      .pending_o     (pending[ch])
    );
  end

  assign irq_a_pending_o = pending[0];
  assign irq_b_pending_o = pending[1];

  // ****************************************************************
  // read port
  // ****************************************************************
  ext_irq_pkg::reg_byte_t rd_data_r;
  ext_irq_pkg::reg_byte_t tctl_view;

  // flags at bits 1 and 3
  always_comb begin
    tctl_view = 8'h00;
    tctl_view[`EXT_IRQ_TCTL_A_EDGE_BIT] = edge_select_r[0];
    tctl_view[`EXT_IRQ_TCTL_A_PEND_BIT] = pending[0];
    tctl_view[`EXT_IRQ_TCTL_B_EDGE_BIT] = edge_select_r[1];
    tctl_view[`EXT_IRQ_TCTL_B_PEND_BIT] = pending[1];
  end

  // read data stands one cycle only, zero otherwise
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      rd_data_r <= 8'h00;
    end else if (rd_en_i) begin
      case (addr_i)
        `EXT_IRQ_CONFIG_OFFSET:    rd_data_r <= ext_irq_config_reg_r;
        `EXT_IRQ_TIMER_CTL_OFFSET: rd_data_r <= tctl_view;
        default:                   rd_data_r <= 8'h00;
      endcase
    end else begin
      rd_data_r <= 8'h00;
    end
  end

  assign rd_data_o = rd_data_r;

endmodule : external_interrupt_inputs
`default_nettype wire

/* File: pkg/ext_irq_cfg.svh */
// constants for the external interrupt inputs block: offsets, fields, resets
`ifndef EXT_IRQ_CFG_SVH
`define EXT_IRQ_CFG_SVH

// ****************************************************************
// register offsets
// ****************************************************************
`define EXT_IRQ_ADDR_W          8
`define EXT_IRQ_DATA_W          8
`define EXT_IRQ_CONFIG_OFFSET   8'h00
`define EXT_IRQ_TIMER_CTL_OFFSET 8'h01

// ****************************************************************
// ext_irq_config_reg fields
// ****************************************************************
`define EXT_IRQ_PIN_SEL_W       3
`define EXT_IRQ_CFG_A_SEL_LSB   0
`define EXT_IRQ_CFG_A_POL_BIT   3
`define EXT_IRQ_CFG_B_SEL_LSB   4
`define EXT_IRQ_CFG_B_POL_BIT   7
`define EXT_IRQ_CONFIG_RESET    8'h00

// ****************************************************************
// timer_control_reg fields
// ****************************************************************
`define EXT_IRQ_TCTL_A_EDGE_BIT 0
`define EXT_IRQ_TCTL_A_PEND_BIT 1
`define EXT_IRQ_TCTL_B_EDGE_BIT 2
`define EXT_IRQ_TCTL_B_PEND_BIT 3
`define EXT_IRQ_TCTL_RESET      8'h00

// ****************************************************************
// encodings
// ****************************************************************
`define EXT_IRQ_SENSE_EDGE      1'b1
`define EXT_IRQ_POL_HIGH        1'b1
`define EXT_IRQ_NUM_INPUTS      2
`define EXT_IRQ_NUM_PINS        8

`endif

/* File: pkg/ext_irq_pkg.sv */
// types shared by the external interrupt inputs block
`default_nettype none
package ext_irq_pkg;

  typedef logic [7:0] reg_byte_t;
  typedef logic [2:0] pin_sel_t;
  typedef logic [1:0] irq_vec_t;

endpackage : ext_irq_pkg
`default_nettype wire

/* File: rtl/ext_irq_detect.sv */
// one external interrupt channel: level or edge detection and pending flag
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_cfg.svh"

module ext_irq_detect (
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  input  wire logic pin_level_i,
  input  wire logic polarity_i,
  input  wire logic edge_select_i,
  input  wire logic vector_ack_i,
  input  wire logic sw_write_i,
  input  wire logic sw_value_i,
  output logic      pending_o
);

  logic active;
  logic active_prev_r;
  logic pending_r;
  logic rise;

  assign active = (polarity_i == `EXT_IRQ_POL_HIGH) ? pin_level_i : ~pin_level_i;
  assign rise   = active & ~active_prev_r;

  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      active_prev_r <= 1'b0;
    end else begin
      active_prev_r <= active;
    end
  end

  // ****************************************************************
  // pending flag
  // ****************************************************************
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      pending_r <= 1'b0;
    end else if (edge_select_i == `EXT_IRQ_SENSE_EDGE) begin
      if (rise) begin
        pending_r <= 1'b1;
      end else if (vector_ack_i) begin
        pending_r <= 1'b0;
      end else if (sw_write_i) begin
        pending_r <= sw_value_i;
      end
    end else begin
      pending_r <= active;
    end
  end

  assign pending_o = pending_r;

endmodule : ext_irq_detect
`default_nettype wire

/* File: dv/ext_irq_src_model.sv */
// model of the external sources that drive the port pins
`timescale 1ns/1ps
`default_nettype none
// ****
// pin sources
// ****
module ext_irq_src_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] want_i,
  output var logic  [7:0] pins_o
);
  initial pins_o = 8'hFF;
  always @(posedge clk_i) pins_o <= want_i;
endmodule : ext_irq_src_model
`default_nettype wire

/* File: dv/ext_irq_assertions.sv */
// checker for the external interrupt inputs block
`timescale 1ns/1ps
`default_nettype none
`include "ext_irq_cfg.svh"
// ****
// checker
// ****
module ext_irq_checker #(parameter int NUM_PINS = 8) (
  input wire logic                ref_clk_i,
  input wire logic                rst_n_i,
  input wire logic [NUM_PINS-1:0] port_pins_i,
  input wire logic [1:0]          vector_ack_i,
  input wire logic [7:0]          addr_i,
  input wire logic [7:0]          wr_data_i,
  input wire logic                wr_en_i,
  input wire logic                rd_en_i,
  input wire logic [7:0]          rd_data_o,
  input wire logic                irq_a_pending_o,
  input wire logic                irq_b_pending_o
);
  logic [7:0] cfg_r;
  logic [1:0] te_r;
  logic       act_a;
  logic       act_b;
  assign act_a = port_pins_i[cfg_r[2:0]] ~^ cfg_r[3];
  assign act_b = port_pins_i[cfg_r[6:4]] ~^ cfg_r[7];
  // shadow of the setup; pins are only watched, never driven
  always_ff @(posedge ref_clk_i) begin
    if (!rst_n_i) begin
      cfg_r <= 8'h00;
      te_r <= 2'h0;
    end else if (wr_en_i && addr_i == 8'h00) begin
      cfg_r <= wr_data_i;
    end else if (wr_en_i && addr_i == 8'h01) begin
      te_r <= {wr_data_i[2], wr_data_i[0]};
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  rd_idle_zero_a: assert property (
    (!$past(rd_en_i) || $past(addr_i) > 8'h01) |-> rd_data_o == 8'h00)
    else $error("read data not zero");
  flag_read_a: assert property ($past(rd_en_i) && $past(addr_i) == 8'h01 |->
    rd_data_o == {4'h0, $past(irq_b_pending_o), $past(te_r[1]), $past(irq_a_pending_o),
    $past(te_r[0])}) else $error("flag read wrong");
  level_high_a: assert property ((!te_r[0] && act_a)[*5] |-> irq_a_pending_o)
    else $error("level flag a low");
  level_low_a: assert property ((!te_r[0] && !act_a)[*5] |-> !irq_a_pending_o)
    else $error("level flag a high");
  level_b_high_a: assert property ((!te_r[1] && act_b)[*5] |-> irq_b_pending_o)
    else $error("level flag b low");
  edge_set_a: assert property ((te_r[0] && !act_a && !wr_en_i)[*3] ##1
    (te_r[0] && act_a && !vector_ack_i[0] && !wr_en_i)[*4] |-> irq_a_pending_o)
    else $error("edge flag a not set");
  ack_clear_a: assert property ((te_r[0] && !act_a)[*4] ##0
    (vector_ack_i[0] && !wr_en_i) |=> !irq_a_pending_o) else $error("ack left flag");
  edge_b_hold_a: assert property (te_r[1] && irq_b_pending_o && !vector_ack_i[1]
    && !wr_en_i |=> irq_b_pending_o) else $error("edge flag b dropped");
  cover property (te_r[0] && vector_ack_i[0] && irq_a_pending_o);
  cover property (!te_r[1] && irq_b_pending_o);
  cover property ($past(rd_en_i) && rd_data_o != 8'h00);
endmodule : ext_irq_checker
bind external_interrupt_inputs ext_irq_checker #(.NUM_PINS(NUM_PINS)) ext_irq_checker_inst (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .port_pins_i(port_pins_i), .addr_i(addr_i),
  .vector_ack_i(vector_ack_i), .wr_data_i(wr_data_i), .wr_en_i(wr_en_i), .rd_en_i(rd_en_i),
  .rd_data_o(rd_data_o), .irq_a_pending_o(irq_a_pending_o), .irq_b_pending_o(irq_b_pending_o));
`default_nettype wire

/* File: dv/external_interrupt_inputs_tb_top.sv */
// testbench for the external interrupt inputs block
`timescale 1ns/1ps
`default_nettype none
// ****
// bench
// ****
module external_interrupt_inputs_tb_top;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, pa, pb, pol, ed;
  logic [1:0] ack = 0;
  logic [2:0] sel;
  logic [7:0] adr = 0, wd = 0, want = 8'hFF, pins, rdat, v, c;
  int failures = 0, n_compared = 0, seed = 22;
  always #2.5 clk = ~clk;
  ext_irq_src_model ext_irq_src_model_inst (.clk_i(clk), .want_i(want), .pins_o(pins));
  external_interrupt_inputs #(.NUM_PINS(8)) external_interrupt_inputs_inst (
    .ref_clk_i(clk), .rst_n_i(rst_n), .port_pins_i(pins), .vector_ack_i(ack), .addr_i(adr),
    .wr_data_i(wd), .wr_en_i(wr), .rd_en_i(rd), .rd_data_o(rdat),
    .irq_a_pending_o(pa), .irq_b_pending_o(pb));
  task automatic final_report();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : final_report
  task automatic chk(string nm, logic [7:0] s, logic [7:0] e);
    n_compared++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    adr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1 v = rdat;
  endtask : bus
  task automatic pulse(logic [1:0] b);
    @(posedge clk);
    ack <= b;
    @(posedge clk);
    ack <= 0;
    #1;
  endtask : pulse
  // lv on the selected pin, random levels on every other pin
  task automatic drive(logic lv);
    @(posedge clk);
    want <= (8'($random(seed)) & ~(8'h01 << sel)) | (8'(lv) << sel);
    tick(6);
  endtask : drive
  function automatic logic [7:0] pnd(int ch);
    return ch ? {7'h0, pb} : {7'h0, pa};
  endfunction : pnd
  // ****
  // reference model: pin history, register shadow and flags from the rules
  // ****
  int q[$], m_cfg = 0, m_te = 0, m_pend[2], m_prev[2], m_act;
  always @(posedge clk) begin
    if (!rst_n) begin
      m_cfg = 0;
      m_te = 0;
      m_pend = '{0, 0};
      m_prev = '{0, 0};
    end else if (q.size() == 2) begin
      chk("model pending a", pnd(0), 8'(m_pend[0]));
      chk("model pending b", pnd(1), 8'(m_pend[1]));
      for (int ch = 0; ch < 2; ch++) begin
        m_act = ((q[0] >> ((m_cfg >> (4 * ch)) & 7)) & 1) == ((m_cfg >> (4 * ch + 3)) & 1);
        if (((m_te >> ch) & 1) == 0)
          m_pend[ch] = m_act;
        else if (m_act && !m_prev[ch])
          m_pend[ch] = 1;
        else if (ack[ch])
          m_pend[ch] = 0;
        else if (wr && adr == 8'h01)
          m_pend[ch] = (wd >> (2 * ch + 1)) & 1;
        m_prev[ch] = m_act;
      end
      if (wr && adr == 8'h00)
        m_cfg = wd;
      if (wr && adr == 8'h01)
        m_te = (wd & 1) | ((wd >> 1) & 2);
    end
    q.push_back(int'(pins));
    if (q.size() > 2)
      void'(q.pop_front());
  end
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1;
    bus(0, 8'h00, 8'h00);
    chk("config reset", v, 8'h00);
    bus(0, 8'h01, 8'h00);
    chk("flags reset", v, 8'h00);
    bus(1, 8'h5A, 8'hFF);
    bus(0, 8'h5A, 8'h00);
    chk("unmapped", v, 8'h00);
    for (int ch = 0; ch < 2; ch++) begin
      for (int m = 0; m < 4; m++) begin
        sel = 3'($random(seed));
        {ed, pol} = 2'(m);
        c = ch ? {pol, sel, 4'h0} : {4'h0, pol, sel};
        bus(1, 8'h00, c);
        bus(0, 8'h00, 8'h00);
        chk("config", v, c);
        bus(1, 8'h01, 8'(ed) << (2 * ch));
        drive(!pol);
        pulse(2'(ch + 1));
        tick(2);
        chk("idle", pnd(ch), 8'h00);
        drive(pol);
        chk("active", pnd(ch), 8'h01);
        bus(0, 8'h01, 8'h00);
        chk("flags", (v >> (2 * ch)) & 8'h03, {6'h0, 1'b1, ed});
        pulse(2'(ch + 1));
        tick(1);
        chk("after ack", pnd(ch), {7'h0, !ed});
        drive(!pol);
        chk("released", pnd(ch), 8'h00);
      end
    end
    // software may raise and drop an edge flag itself
    sel = 3'h0;
    bus(1, 8'h00, 8'h08);
    drive(1'b0);
    bus(1, 8'h01, 8'h01);
    bus(1, 8'h01, 8'h03);
    bus(0, 8'h01, 8'h00);
    chk("soft set", v & 8'h03, 8'h03);
    bus(1, 8'h01, 8'h01);
    tick(1);
    chk("soft clear", pnd(0), 8'h00);
    final_report();
  end
  initial begin
    #100000;
    failures++;
    final_report();
  end
endmodule : external_interrupt_inputs_tb_top
`default_nettype wire
